//--- core/uart_event_interrupt_enables.sv
// Interrupt enables, event flags and receive-end shortcut of the serial port
`timescale 1ns/1ps
module uart_event_interrupt_enables #(
	parameter int MAXCNT_WIDTH = uart_irq_pkg::MAXCNT_W
) (
	input  wire logic                      clock,
	input  wire logic                      rstn,
	input  wire uart_irq_pkg::bus_req_t    bus,
	input  wire uart_irq_pkg::engine_evt_t engine,
	input  wire logic                      clear_to_send_n,
	output logic [uart_irq_pkg::DATA_W-1:0] rd_data,
	output logic                           irq,
	output logic                           halt_receiver,
	output logic                           rx_buffer_end
);
	import uart_irq_pkg::*;

	// Counter width must fit the data bus
	if (MAXCNT_WIDTH < 1 || MAXCNT_WIDTH > 16) begin : g_bad_width
		$error("MAXCNT_WIDTH must be 1 to 16");
	end

	logic [31:0]             irq_mask;
	logic [31:0]             status;
	logic                    rx_end_to_halt_shortcut;
	logic [MAXCNT_WIDTH-1:0] rx_maxcnt;
	logic [MAXCNT_WIDTH-1:0] rx_count;
	logic                    cts_meta;
	logic                    cts_sync;
	logic                    cts_prev;
	logic                    cts_active_evt;
	logic                    clear_to_send_dropped;
	logic                    rx_end_evt;
	logic [31:0]             events;
	logic [31:0]             w1c;
	logic [31:0]             next_status;
	logic [31:0]             next_mask;

	// Address hit for a write strobe
	function automatic logic wr_hit(input bus_req_t r, input logic [11:0] off);
		return r.wr && (r.addr == off);
	endfunction : wr_hit

	// Two flops before the pin reaches any logic
	always_ff @(posedge clock) begin
		if (!rstn) begin
			cts_meta <= CTS_IDLE;
			cts_sync <= CTS_IDLE;
			cts_prev <= CTS_IDLE;
		end else begin
			cts_meta <= clear_to_send_n;
			cts_sync <= cts_meta;
			cts_prev <= cts_sync;
		end
	end

	// Edges of the synchronised line; active low, so a fall means activated
	assign cts_active_evt        = cts_prev && !cts_sync;
	assign clear_to_send_dropped = !cts_prev && cts_sync;

	// Buffer end when the stored count reaches the maximum; zero never ends
	assign rx_end_evt = engine.rx_stored && (rx_maxcnt != '0)
		&& (rx_count == rx_maxcnt - MAXCNT_WIDTH'(1));

	// Received byte counter, restarted by each receive start
	always_ff @(posedge clock) begin
		if (!rstn) begin
			rx_count <= '0;
		end else if (engine.rx_start || rx_end_evt) begin
			rx_count <= '0;
		end else if (engine.rx_stored) begin
			rx_count <= rx_count + MAXCNT_WIDTH'(1);
		end
	end

	// Gather events into the shared bit layout
	always_comb begin
		events                  = '0;
		events[BIT_CTS_ACTIVE]  = cts_active_evt;
		events[BIT_CTS_DROPPED] = clear_to_send_dropped;
		events[BIT_RX_BYTE]     = engine.rx_byte;
		events[BIT_RX_END]      = rx_end_evt;
		events[BIT_TX_BYTE]     = engine.tx_byte;
		events[BIT_TX_END]      = engine.tx_end;
		events[BIT_ERROR]       = engine.error;
		events[BIT_RX_TIMEOUT]  = engine.rx_timeout;
		events[BIT_RX_RUNNING]  = engine.rx_running;
		events[BIT_TX_RUNNING]  = engine.tx_running;
		events[BIT_TX_HALTED]   = engine.tx_halted;
	end

	// Sticky flags: a set in the clearing cycle wins, so no event is lost
	assign w1c         = wr_hit(bus, OFF_STATUS) ? bus.wdata : '0;
	assign next_status = ((status & ~w1c) | events) & EVENT_BITS;

	always_ff @(posedge clock) begin
		if (!rstn) begin
			status <= STATUS_RESET;
		end else begin
			status <= next_status;
		end
	end

	// Enable register: direct write, or set/clear aliases that touch only ones
	always_comb begin
		next_mask = irq_mask;
		if (wr_hit(bus, OFF_MASK)) begin
			next_mask = bus.wdata;
		end else if (wr_hit(bus, OFF_MASK_SET)) begin
			next_mask = irq_mask | bus.wdata;
		end else if (wr_hit(bus, OFF_MASK_CLEAR)) begin
			next_mask = irq_mask & ~bus.wdata;
		end
		next_mask = next_mask & EVENT_BITS;
	end

	always_ff @(posedge clock) begin
		if (!rstn) begin
			irq_mask <= MASK_RESET;
		end else begin
			irq_mask <= next_mask;
		end
	end

	// Shortcut and buffer size configuration
	always_ff @(posedge clock) begin
		if (!rstn) begin
			rx_end_to_halt_shortcut <= SHORT_RESET;
			rx_maxcnt               <= '0;
		end else begin
			if (wr_hit(bus, OFF_SHORTCUTS)) begin
				rx_end_to_halt_shortcut <= bus.wdata[BIT_SHORT_HALT];
			end
			if (wr_hit(bus, OFF_RX_MAXCNT)) begin
				rx_maxcnt <= bus.wdata[MAXCNT_WIDTH-1:0];
			end
		end
	end

	// Task pulses out, registered so they line up with the event flag
	always_ff @(posedge clock) begin
		if (!rstn) begin
			halt_receiver <= 1'b0;
			rx_buffer_end <= 1'b0;
		end else begin
			halt_receiver <= rx_end_evt && rx_end_to_halt_shortcut;
			rx_buffer_end <= rx_end_evt;
		end
	end

	// Level interrupt; one cycle behind the flags, traded for a clean flop output
	always_ff @(posedge clock) begin
		if (!rstn) begin
			irq <= 1'b0;
		end else begin
			irq <= |(status & irq_mask);
		end
	end

	// Read port; all three enable addresses show the same state
	always_ff @(posedge clock) begin
		if (!rstn) begin
			rd_data <= '0;
		end else if (bus.rd) begin
			unique case (bus.addr)
				OFF_MASK,
				OFF_MASK_SET,
				OFF_MASK_CLEAR: rd_data <= irq_mask;
				OFF_STATUS:     rd_data <= status;
				OFF_SHORTCUTS: begin
					rd_data                 <= '0;
					rd_data[BIT_SHORT_HALT] <= rx_end_to_halt_shortcut;
				end
				OFF_RX_MAXCNT:  rd_data <= DATA_W'(rx_maxcnt);
				default:        rd_data <= '0;
			endcase
		end else begin
			rd_data <= '0;
		end
	end

	// Checks tied to the logic above
	property p_mask_write;
		@(posedge clock) disable iff (!rstn)
		(bus.wr && bus.addr == OFF_MASK) |=> (irq_mask == ($past(bus.wdata) & EVENT_BITS));
	endproperty
	a_mask_write: assert property (p_mask_write) else $error("enable write not stored");

	property p_set_alias;
		@(posedge clock) disable iff (!rstn)
		(bus.wr && bus.addr == OFF_MASK_SET)
			|=> (irq_mask == (($past(irq_mask) | $past(bus.wdata)) & EVENT_BITS));
	endproperty
	a_set_alias: assert property (p_set_alias) else $error("set alias wrong");

	property p_clear_alias;
		@(posedge clock) disable iff (!rstn)
		(bus.wr && bus.addr == OFF_MASK_CLEAR)
			|=> (irq_mask == ($past(irq_mask) & ~$past(bus.wdata)));
	endproperty
	a_clear_alias: assert property (p_clear_alias) else $error("clear alias wrong");

	property p_alias_zero;
		@(posedge clock) disable iff (!rstn)
		(bus.wr && bus.wdata == '0 && (bus.addr == OFF_MASK_SET || bus.addr == OFF_MASK_CLEAR))
			|=> $stable(irq_mask);
	endproperty
	a_alias_zero: assert property (p_alias_zero) else $error("zero alias write changed enables");

	property p_alias_read;
		@(posedge clock) disable iff (!rstn)
		(bus.rd && (bus.addr == OFF_MASK_SET || bus.addr == OFF_MASK_CLEAR) && !bus.wr)
			|=> (rd_data == $past(irq_mask));
	endproperty
	a_alias_read: assert property (p_alias_read) else $error("alias read not enable state");

	// An older deactivated flag may still stand; only a fresh one would be wrong
	property p_cts_fall;
		@(posedge clock) disable iff (!rstn)
		$fell(cts_sync) |=> status[BIT_CTS_ACTIVE]
			&& (!status[BIT_CTS_DROPPED] || $past(status[BIT_CTS_DROPPED]));
	endproperty
	a_cts_fall: assert property (p_cts_fall) else $error("activated flag missing");

	property p_cts_rise;
		@(posedge clock) disable iff (!rstn)
		$rose(cts_sync) |=> status[BIT_CTS_DROPPED];
	endproperty
	a_cts_rise: assert property (p_cts_rise) else $error("deactivated flag missing");

	property p_rx_end;
		@(posedge clock) disable iff (!rstn)
		(engine.rx_stored && !engine.rx_start && rx_maxcnt != '0
			&& rx_count == rx_maxcnt - MAXCNT_WIDTH'(1))
			|=> rx_buffer_end && status[BIT_RX_END] ##1 (rx_count == '0 || $past(engine.rx_stored));
	endproperty
	a_rx_end: assert property (p_rx_end) else $error("buffer end missed at maximum");

	property p_shortcut;
		@(posedge clock) disable iff (!rstn)
		rx_buffer_end |-> (halt_receiver == $past(rx_end_to_halt_shortcut));
	endproperty
	a_shortcut: assert property (p_shortcut) else $error("shortcut halt wrong");

	property p_irq_level;
		@(posedge clock) disable iff (!rstn)
		(|(status & irq_mask)) |=> irq;
	endproperty
	a_irq_level: assert property (p_irq_level) else $error("enabled flag gave no interrupt");

	property p_irq_blocked;
		@(posedge clock) disable iff (!rstn)
		((status & irq_mask) == '0) |=> !irq;
	endproperty
	a_irq_blocked: assert property (p_irq_blocked) else $error("disabled event raised interrupt");

	// Enables move only on a write to one of their three addresses
	property p_mask_hold;
		@(posedge clock) disable iff (!rstn)
		!bus.wr |=> $stable(irq_mask);
	endproperty
	a_mask_hold: assert property (p_mask_hold) else $error("enables moved without a write");

	property p_mask_foreign;
		@(posedge clock) disable iff (!rstn)
		(bus.wr && bus.addr != OFF_MASK && bus.addr != OFF_MASK_SET && bus.addr != OFF_MASK_CLEAR)
			|=> $stable(irq_mask);
	endproperty
	a_mask_foreign: assert property (p_mask_foreign) else $error("foreign write changed enables");

	property p_set_keeps;
		@(posedge clock) disable iff (!rstn)
		(bus.wr && bus.addr == OFF_MASK_SET) |=> (($past(irq_mask) & ~irq_mask) == '0);
	endproperty
	a_set_keeps: assert property (p_set_keeps) else $error("set alias lowered an enable");

	property p_clear_keeps;
		@(posedge clock) disable iff (!rstn)
		(bus.wr && bus.addr == OFF_MASK_CLEAR) |=> ((irq_mask & ~$past(irq_mask)) == '0);
	endproperty
	a_clear_keeps: assert property (p_clear_keeps) else $error("clear alias raised an enable");

	// Reads of the enable state, and read data that stands one cycle only
	property p_mask_read;
		@(posedge clock) disable iff (!rstn)
		(bus.rd && bus.addr == OFF_MASK) |=> (rd_data == $past(irq_mask));
	endproperty
	a_mask_read: assert property (p_mask_read) else $error("enable read wrong");

	property p_clear_read;
		@(posedge clock) disable iff (!rstn)
		(bus.rd && bus.addr == OFF_MASK_CLEAR) |=> (rd_data == $past(irq_mask));
	endproperty
	a_clear_read: assert property (p_clear_read) else $error("clear alias read wrong");

	property p_read_idle;
		@(posedge clock) disable iff (!rstn)
		!bus.rd |=> (rd_data == '0);
	endproperty
	a_read_idle: assert property (p_read_idle) else $error("read data stood too long");

	// Flags: a new event always lands, and only a clear takes one away
	property p_event_sets;
		@(posedge clock) disable iff (!rstn)
		(events != '0) |=> ((status & $past(events)) == $past(events));
	endproperty
	a_event_sets: assert property (p_event_sets) else $error("event flag lost");

	property p_status_hold;
		@(posedge clock) disable iff (!rstn)
		(!bus.wr && events == '0) |=> $stable(status);
	endproperty
	a_status_hold: assert property (p_status_hold) else $error("flags moved with no cause");

	property p_status_clear;
		@(posedge clock) disable iff (!rstn)
		(bus.wr && bus.addr == OFF_STATUS && events == '0)
			|=> (status == ($past(status) & ~$past(bus.wdata)));
	endproperty
	a_status_clear: assert property (p_status_clear) else $error("flag clear wrong");

	// Buffer end needs a stored byte, a nonzero maximum and a fresh count
	property p_rx_end_only;
		@(posedge clock) disable iff (!rstn)
		rx_buffer_end |-> $past(engine.rx_stored);
	endproperty
	a_rx_end_only: assert property (p_rx_end_only) else $error("buffer end without a stored byte");

	property p_rx_zero_max;
		@(posedge clock) disable iff (!rstn)
		(rx_maxcnt == '0) |=> !rx_buffer_end;
	endproperty
	a_rx_zero_max: assert property (p_rx_zero_max) else $error("zero maximum ended the buffer");

	property p_rx_restart;
		@(posedge clock) disable iff (!rstn)
		engine.rx_start |=> (rx_count == '0);
	endproperty
	a_rx_restart: assert property (p_rx_restart) else $error("receive start kept the count");

	// The halt task never fires without the buffer end beside it
	property p_halt_needs_end;
		@(posedge clock) disable iff (!rstn)
		halt_receiver |-> rx_buffer_end;
	endproperty
	a_halt_needs_end: assert property (p_halt_needs_end) else $error("halt without buffer end");
endmodule : uart_event_interrupt_enables

//--- shared/uart_irq_pkg.sv
// Constants and carriers for the serial port interrupt-enable block
// Functional notes
// - Read-write enable register, one bit per event
// - Separate enables for clear-to-send fall and rise
// - Separate enables for byte ready and buffer end
// - Set alias writes ones on, reads enables
// - Clear alias writes ones off, reads enables
// - Aliases share bits; zero writes change nothing
// - Clear-to-send low fires activated, high deactivated
// - Buffer end fires when count reaches a nonzero maximum
package uart_irq_pkg;
	localparam int         ADDR_W         = 12;
	localparam int         DATA_W         = 32;
	// Register offsets
	localparam logic [11:0] OFF_SHORTCUTS  = 12'h200;
	localparam logic [11:0] OFF_MASK       = 12'h300;
	localparam logic [11:0] OFF_MASK_SET   = 12'h304;
	localparam logic [11:0] OFF_MASK_CLEAR = 12'h308;
	localparam logic [11:0] OFF_STATUS     = 12'h320;
	localparam logic [11:0] OFF_RX_MAXCNT  = 12'h538;
	// Event bit positions, shared by mask, set, clear and status; BIT_SHORT_HALT is the shortcut register bit
	localparam int BIT_CTS_ACTIVE   = 0;
	localparam int BIT_CTS_DROPPED  = 1;
	localparam int BIT_RX_BYTE      = 2;
	localparam int BIT_RX_END       = 4;
	localparam int BIT_TX_BYTE      = 7;
	localparam int BIT_TX_END       = 8;
	localparam int BIT_ERROR        = 9;
	localparam int BIT_RX_TIMEOUT   = 17;
	localparam int BIT_RX_RUNNING   = 19;
	localparam int BIT_TX_RUNNING   = 20;
	localparam int BIT_TX_HALTED    = 22;
	localparam int BIT_SHORT_HALT   = 6;
	// Implemented bits; all others read as zero
	localparam logic [31:0] EVENT_BITS     = 32'h005A_0397;
	localparam logic [31:0] MASK_RESET     = 32'h0000_0000;
	localparam logic [31:0] STATUS_RESET   = 32'h0000_0000;
	localparam logic        SHORT_RESET    = 1'b0;
	localparam logic        CTS_IDLE       = 1'b1;
	localparam int          MAXCNT_W       = 8;

	// Register bus request
	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic              wr;
		logic              rd;
	} bus_req_t;

	// Event pulses from the serial engine, same clock
	typedef struct packed {
		logic rx_byte;
		logic rx_stored;
		logic rx_start;
		logic tx_byte;
		logic tx_end;
		logic error;
		logic rx_timeout;
		logic rx_running;
		logic tx_running;
		logic tx_halted;
	} engine_evt_t;
endpackage : uart_irq_pkg

//--- sim/testbench.sv
// Self-checking bench for the serial port interrupt-enable block
`timescale 1ns/1ps
module testbench;
	import uart_irq_pkg::*;
	logic              clock;
	logic              rstn;
	bus_req_t          bus;
	engine_evt_t       engine;
	engine_evt_t       stored;
	logic              clear_to_send_n;
	logic [DATA_W-1:0] rd_data;
	logic              irq;
	logic              halt_receiver;
	logic              rx_buffer_end;
	logic [31:0]       exp;
	int                n_mismatch;
	int                num_checks;

	uart_event_interrupt_enables #(.MAXCNT_WIDTH(MAXCNT_W)) DUT (
		.clock           (clock),
		.rstn            (rstn),
		.bus             (bus),
		.engine          (engine),
		.clear_to_send_n (clear_to_send_n),
		.rd_data         (rd_data),
		.irq             (irq),
		.halt_receiver   (halt_receiver),
		.rx_buffer_end   (rx_buffer_end)
	);

	// 50 MHz system clock
	initial begin
		clock = 1'b0;
		forever #10 clock = ~clock;
	end

	// Verdict and end of run; also reached by the watchdog
	task automatic final_report();
		$display("Checks %0d, mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : final_report

	task automatic check(input logic [31:0] got, input logic [31:0] want);
		num_checks++;
		if (got !== want) begin
			n_mismatch++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, want);
		end
	endtask : check

	task automatic check_bit(input logic got, input logic want);
		check({31'h0, got}, {31'h0, want});
	endtask : check_bit

	// One-cycle write strobe, released at the next edge
	task automatic write_reg(input logic [11:0] addr, input logic [31:0] data);
		@(posedge clock);
		bus <= '{addr: addr, wdata: data, wr: 1'b1, rd: 1'b0};
		@(posedge clock);
		bus.wr <= 1'b0;
	endtask : write_reg

	// Read data only stands in the cycle after the strobe
	task automatic read_check(input logic [11:0] addr, input logic [31:0] want);
		@(posedge clock);
		bus <= '{addr: addr, wdata: 32'h0000_0000, wr: 1'b0, rd: 1'b1};
		@(posedge clock);
		bus.rd <= 1'b0;
		#1;
		check(rd_data, want);
	endtask : read_check

	task automatic pulse(input engine_evt_t e);
		@(posedge clock);
		engine <= e;
		@(posedge clock);
		engine <= '0;
	endtask : pulse

	task automatic idle(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask : idle

	// One engine event: its own flag alone, irq only while its enable is on
	task automatic event_check(input engine_evt_t e, input int pos);
		pulse(e);
		read_check(OFF_STATUS, 32'h0000_0001 << pos);
		write_reg(OFF_MASK_SET, 32'h0000_0001 << pos);
		idle(2);
		check_bit(irq, 1'b1);
		write_reg(OFF_MASK_CLEAR, 32'h0000_0001 << pos);
		idle(2);
		check_bit(irq, 1'b0);
		write_reg(OFF_STATUS, 32'h0000_0001 << pos);
	endtask : event_check

	// Watchdog: a hang counts as a mismatch
	initial begin
		#1_000_000;
		n_mismatch++;
		final_report();
	end

	initial begin
		n_mismatch = 0;
		num_checks = 0;
		rstn = 1'b0;
		bus = '0;
		engine = '0;
		stored = '0;
		clear_to_send_n = 1'b1;
		repeat (6) @(posedge clock);
		rstn <= 1'b1;

		read_check(OFF_MASK, MASK_RESET);
		read_check(OFF_MASK_SET, MASK_RESET);
		read_check(OFF_MASK_CLEAR, MASK_RESET);
		read_check(12'h3FC, 32'h0000_0000);
		write_reg(OFF_MASK, 32'hFFFF_FFFF);
		read_check(OFF_MASK, EVENT_BITS);
		write_reg(OFF_MASK, 32'h0000_0000);
		write_reg(12'h3FC, 32'hFFFF_FFFF);
		read_check(OFF_MASK, 32'h0000_0000);
		$display("test register map done");

		// Each enable turned on alone, then off alone, so neighbours must not move
		exp = 32'h0000_0000;
		for (int i = 0; i < 32; i++) begin
			if (EVENT_BITS[i]) begin
				write_reg(OFF_MASK_SET, 32'h0000_0001 << i);
				exp[i] = 1'b1;
				read_check(OFF_MASK_SET, exp);
			end
		end
		write_reg(OFF_MASK_SET, 32'h0000_0000);
		write_reg(OFF_MASK_CLEAR, 32'h0000_0000);
		read_check(OFF_MASK, EVENT_BITS);
		for (int i = 0; i < 32; i++) begin
			if (EVENT_BITS[i]) begin
				write_reg(OFF_MASK_CLEAR, 32'h0000_0001 << i);
				exp[i] = 1'b0;
				read_check(OFF_MASK_CLEAR, exp);
			end
		end
		$display("test set and clear aliases done");

		// Error event gated by its enable
		write_reg(OFF_MASK_SET, 32'h0000_0200);
		stored = '0;
		stored.error = 1'b1;
		pulse(stored);
		idle(2);
		check_bit(irq, 1'b1);
		write_reg(OFF_MASK_CLEAR, 32'h0000_0200);
		idle(2);
		check_bit(irq, 1'b0);
		write_reg(OFF_MASK_SET, 32'h0000_0200);
		idle(2);
		check_bit(irq, 1'b1);
		write_reg(OFF_STATUS, 32'h0000_0200);
		idle(2);
		check_bit(irq, 1'b0);
		$display("test interrupt gating done");

		// Each engine event but error on its own flag and enable
		event_check(engine_evt_t'{rx_byte: 1'b1, default: 1'b0}, BIT_RX_BYTE);
		event_check(engine_evt_t'{tx_byte: 1'b1, default: 1'b0}, BIT_TX_BYTE);
		event_check(engine_evt_t'{tx_end: 1'b1, default: 1'b0}, BIT_TX_END);
		event_check(engine_evt_t'{rx_timeout: 1'b1, default: 1'b0}, BIT_RX_TIMEOUT);
		event_check(engine_evt_t'{rx_running: 1'b1, default: 1'b0}, BIT_RX_RUNNING);
		event_check(engine_evt_t'{tx_running: 1'b1, default: 1'b0}, BIT_TX_RUNNING);
		event_check(engine_evt_t'{tx_halted: 1'b1, default: 1'b0}, BIT_TX_HALTED);
		$display("test engine events done");

		// Clear and new event in one cycle: the event must survive
		pulse(engine_evt_t'{error: 1'b1, default: 1'b0});
		@(posedge clock);
		bus    <= '{addr: OFF_STATUS, wdata: 32'h0000_0200, wr: 1'b1, rd: 1'b0};
		engine <= engine_evt_t'{error: 1'b1, default: 1'b0};
		@(posedge clock);
		bus.wr <= 1'b0;
		engine <= '0;
		read_check(OFF_STATUS, 32'h0000_0200);
		write_reg(OFF_STATUS, 32'h0000_0200);
		read_check(OFF_STATUS, 32'h0000_0000);
		$display("test clear against event done");

		// Flow-control pin edges; only the falling one is enabled
		write_reg(OFF_MASK, 32'h0000_0001);
		@(posedge clock);
		clear_to_send_n <= 1'b0;
		idle(6);
		read_check(OFF_STATUS, 32'h0000_0001);
		check_bit(irq, 1'b1);
		write_reg(OFF_STATUS, 32'h0000_0001);
		clear_to_send_n <= 1'b1;
		idle(6);
		read_check(OFF_STATUS, 32'h0000_0002);
		check_bit(irq, 1'b0);
		write_reg(OFF_STATUS, 32'h0000_0002);
		$display("test flow-control edges done");

		// Buffer end after two stored bytes, shortcut on then off
		write_reg(OFF_MASK, 32'h0000_0004);
		write_reg(OFF_RX_MAXCNT, 32'h0000_0002);
		write_reg(OFF_SHORTCUTS, 32'h0000_0040);
		read_check(OFF_SHORTCUTS, 32'h0000_0040);
		stored = '0;
		stored.rx_stored = 1'b1;
		pulse(stored);
		#1;
		check_bit(rx_buffer_end, 1'b0);
		pulse(stored);
		#1;
		check_bit(rx_buffer_end, 1'b1);
		check_bit(halt_receiver, 1'b1);
		idle(2);
		check_bit(irq, 1'b0);
		stored = '0;
		stored.rx_byte = 1'b1;
		pulse(stored);
		idle(2);
		check_bit(irq, 1'b1);
		write_reg(OFF_STATUS, 32'h0000_0014);
		write_reg(OFF_SHORTCUTS, 32'h0000_0000);
		stored = '0;
		stored.rx_stored = 1'b1;
		pulse(stored);
		pulse(stored);
		#1;
		check_bit(rx_buffer_end, 1'b1);
		check_bit(halt_receiver, 1'b0);
		$display("test buffer end and shortcut done");

		// Receive start restarts the count; a zero maximum never ends
		read_check(OFF_RX_MAXCNT, 32'h0000_0002);
		pulse(stored);
		pulse(engine_evt_t'{rx_start: 1'b1, default: 1'b0});
		pulse(stored);
		#1;
		check_bit(rx_buffer_end, 1'b0);
		pulse(stored);
		#1;
		check_bit(rx_buffer_end, 1'b1);
		write_reg(OFF_RX_MAXCNT, 32'h0000_0000);
		repeat (2) pulse(stored);
		#1;
		check_bit(rx_buffer_end, 1'b0);
		$display("test receive restart done");

		// Reset in mid-run brings the enable, flag and shortcut registers and irq back
		write_reg(OFF_MASK, 32'hFFFF_FFFF);
		@(posedge clock);
		rstn <= 1'b0;
		repeat (2) @(posedge clock);
		rstn <= 1'b1;
		read_check(OFF_MASK, MASK_RESET);
		read_check(OFF_STATUS, STATUS_RESET);
		read_check(OFF_SHORTCUTS, 32'h0000_0000);
		check_bit(irq, 1'b0);
		$display("test reset in mid-run done");
		final_report();
	end
endmodule : testbench
